/* hw/pics_pkg.sv */
// package for the phy interrupt / cable diagnostic / status register bank
package pics_pkg;

  // register indices (printed offsets are not multiples of four: byte address = 4 * index)
  localparam logic [7:0]  IDX_INT_CTRL_STAT   = 8'h1b;
  localparam logic [7:0]  IDX_CABLE_DIAG      = 8'h1d;
  localparam logic [7:0]  IDX_PHY_STAT_ONE    = 8'h1e;
  localparam logic [7:0]  IDX_PHY_CTRL_TWO    = 8'h1f;

  // interrupt control/status field positions
  localparam int          INT_LINKUP_EN_BIT   = 8;
  localparam int          INT_EN_HI_BIT       = 15;
  localparam int          INT_EN_LO_BIT       = 9;
  localparam int          INT_FLAG_COUNT      = 8;

  // cable diagnostic field positions
  localparam int          CD_START_BIT        = 15;
  localparam int          CD_RESULT_HI        = 14;
  localparam int          CD_RESULT_LO        = 13;
  localparam int          CD_SHORT_BIT        = 12;
  localparam int          CD_RSVD_HI          = 11;
  localparam int          CD_RSVD_LO          = 9;
  localparam int          CD_DIST_HI          = 8;

  // phy status one field positions
  localparam int          PS_PAUSE_BIT        = 9;
  localparam int          PS_LINK_BIT         = 8;
  localparam int          PS_POL_BIT          = 7;

  // phy control two: interrupt level select
  localparam int          PC_INT_LEVEL_BIT    = 9;

  // reset values
  localparam logic [7:0]  INT_EN_RESET        = 8'h00;
  localparam logic [7:0]  INT_FLAG_RESET      = 8'h00;
  localparam logic [1:0]  CD_RESULT_RESET     = 2'h0;
  localparam logic [2:0]  CD_RSVD_RESET       = 3'h0;
  localparam logic [8:0]  CD_DIST_RESET       = 9'h000;
  localparam logic        INT_LEVEL_RESET     = 1'b0;

  // cable test result codes
  typedef enum logic [1:0]
  {
    PICS_CD_NORMAL = 2'h0,
    PICS_CD_OPEN   = 2'h1,
    PICS_CD_SHORT  = 2'h2,
    PICS_CD_FAIL   = 2'h3
  } pics_cd_result_t;

  // event strobes from the phy core, one bit per flag, bit 0 = link up
  typedef struct packed
  {
    logic jabber;
    logic rx_error;
    logic page_rx;
    logic par_det_fault;
    logic lp_ack;
    logic link_down;
    logic remote_fault;
    logic link_up;
  } pics_events_t;

  // cable test outcome delivered by the analog test engine
  typedef struct packed
  {
    logic            done;
    pics_cd_result_t result;
    logic            short_cable;
    logic [8:0]      distance;
  } pics_cd_report_t;

  // live status levels from the phy core
  typedef struct packed
  {
    logic pause_capable;
    logic link_up;
    logic polarity_rev;
  } pics_status_t;

endpackage

/* hw/pics_regs.sv */
// register bank: interrupt control/status, cable diagnostic, phy status, over apb
//
// Behaviour
// - bit 8 enables link-up interrupt, reset 0
// - bit 6 flags receive error, self-clearing
// - bit 5 flags page received, self-clearing
// - bit 4 flags parallel detect fault, self-clearing
// - bit 3 flags link partner acknowledge
// - bit 2 flags link down, self-clearing
// - bit 1 flags remote fault, self-clearing
// - bit 0 flags link up, self-clearing
// - write 1 bit 15 starts test, self-clears
// - results valid once start bit reads 0
// - bits 14:13 hold test result code
// - bit 12 flags cable under ten meters
// - status bit 9 shows flow control capability
// - status bit 7 shows reversed polarity
// - bits 15:9 enable flags 7:1 in order
// - interrupt pin polarity selectable, default low
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module pics_regs
  import pics_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            rst,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // phy core side
  input  wire pics_events_t    events,
  input  wire pics_cd_report_t cd_report,
  input  wire pics_status_t    status,
  output logic                 cd_start,
  output logic                 irq_pin
);

  // decode of a word index from a byte address
  function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
    hit = (addr[1:0] == 2'h0) && (addr[11:2] == {2'h0, idx});
  endfunction

  // cable test sequencer states
  typedef enum logic
  {
    PICS_CD_IDLE,
    PICS_CD_RUN
  } pics_cd_state_t;

  // word layouts as software sees them:
  //   interrupt word: enables in 15:8, sticky event flags in 7:0
  //   cable word: start/busy 15, result 14:13, short 12, spare 11:9, distance 8:0
  //   status word: pause 9, link 8, polarity 7, everything else reads 0
  //   control two word: only the interrupt level bit 9 lives here
  logic [7:0]            int_en;       // bit 0 = link-up enable, bits 7:1 = enables 15:9
  logic [7:0]            int_flag;
  logic                  cd_busy;
  pics_cd_result_t       cd_result;
  logic                  cd_short;
  logic [2:0]            cd_rsvd;
  logic [8:0]            cd_dist;
  pics_status_t          stat_q;
  logic                  int_level;
  logic                  setup;
  logic                  acc_wr;
  logic                  acc_rd;
  logic                  sel_int;
  logic                  sel_cd;
  logic                  sel_ps;
  logic                  sel_pc;
  logic                  mapped;
  logic [15:0]           next_rdata;
  logic [7:0]            next_flag;
  logic                  any_pending;
  logic                  access;
  logic                  acc_rd_done;
  logic [7:0]            clr_mask;
  logic [7:0]            pair_hit;
  pics_cd_state_t        cd_state;

  // setup marks the request; the access edge is where the master sees pready high
  assign setup   = psel && !penable;
  assign access  = psel && penable && pready;
  assign sel_int = hit(paddr, IDX_INT_CTRL_STAT);
  assign sel_cd  = hit(paddr, IDX_CABLE_DIAG);
  assign sel_ps  = hit(paddr, IDX_PHY_STAT_ONE);
  assign sel_pc  = hit(paddr, IDX_PHY_CTRL_TWO);
  assign mapped  = sel_int || sel_cd || sel_ps || sel_pc;
  // writes and read side effects land only on the completing edge, never at setup
  assign acc_wr      = access && pwrite && mapped;
  assign acc_rd      = setup && !pwrite && mapped;
  assign acc_rd_done = access && !pwrite && mapped;

  // ready asserted in the cycle after setup: one wait-free access phase
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !mapped;   // unmapped word answers with an error
    end
  end

  // enables, written by software
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      int_en <= INT_EN_RESET;
    else if (acc_wr && sel_int)
    begin
      int_en[0]   <= pwdata[INT_LINKUP_EN_BIT];
      int_en[7:1] <= pwdata[INT_EN_HI_BIT:INT_EN_LO_BIT];
    end
  end

  // image of the flags handed out at setup; only those are cleared at the access edge,
  // so an event landing between setup and completion is not thrown away
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      clr_mask <= INT_FLAG_RESET;
    else if (acc_rd && sel_int)
      clr_mask <= int_flag;
    else if (access)
      clr_mask <= INT_FLAG_RESET;
  end

  // one sticky flag per event; set wins over the read clear
  generate
    for (genvar g = 0; g < INT_FLAG_COUNT; g++)
    begin : g_flag
      always_comb
      begin
        next_flag[g] = int_flag[g];
        if (acc_rd_done && sel_int && clr_mask[g])
          next_flag[g] = 1'b0;
        if (events[g])
          next_flag[g] = 1'b1;
      end

      always_ff @(posedge clk_sys)
      begin
        if (rst)
          int_flag[g] <= INT_FLAG_RESET[g];
        else
          int_flag[g] <= next_flag[g];
      end

      // enable bit g pairs with flag g: bit 0 link up, bits 7:1 jabber to remote fault
      assign pair_hit[g] = int_flag[g] && int_en[g];
    end
  endgenerate

  // interrupt level select lives in bit 9 of the phy control two word
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      int_level <= INT_LEVEL_RESET;
    else if (acc_wr && sel_pc)
      int_level <= pwdata[PC_INT_LEVEL_BIT];
  end

  // pending from the registered flags so the pin follows the visible state
  assign any_pending = |pair_hit;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      irq_pin <= 1'b1;               // inactive high for the active-low default while in reset
    else
      irq_pin <= int_level ? any_pending : !any_pending;
  end

  // cable test sequencer: runs from the start write until the engine reports done;
  // a done seen while idle is ignored, the engine's output is junk between reports
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cd_state <= PICS_CD_IDLE;
    else
    begin
      case (cd_state)
        PICS_CD_IDLE:
          if (acc_wr && sel_cd && pwdata[CD_START_BIT])
            cd_state <= PICS_CD_RUN;
        PICS_CD_RUN:
          if (cd_report.done)
            cd_state <= PICS_CD_IDLE;
        default:
          cd_state <= PICS_CD_IDLE;
      endcase
    end
  end

  // start bit reads back 1 for as long as the test runs
  assign cd_busy = (cd_state == PICS_CD_RUN);

  // start pulse only from idle, so a second 1 while running does not restart
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cd_start <= 1'b0;
    else
      cd_start <= acc_wr && sel_cd && pwdata[CD_START_BIT] && !cd_busy;
  end

  // results latched with done, on the same edge that drops the busy bit
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cd_result <= PICS_CD_NORMAL;
      cd_short  <= 1'b0;
      cd_dist   <= CD_DIST_RESET;
    end
    else if (cd_busy && cd_report.done)
    begin
      cd_result <= cd_report.result;
      cd_short  <= cd_report.short_cable;
      cd_dist   <= cd_report.distance;
    end
  end

  // reserved read/write bits 11:9 kept as plain storage
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cd_rsvd <= CD_RSVD_RESET;
    else if (acc_wr && sel_cd)
      cd_rsvd <= pwdata[CD_RSVD_HI:CD_RSVD_LO];
  end

  // live status sampled once; polarity is unknown at reset, taken as 0
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      stat_q <= '0;
    else
      stat_q <= status;
  end

  // read mux
  always_comb
  begin
    next_rdata = 16'h0000;
    if (sel_int)
      next_rdata = {int_en[7:1], int_en[0], int_flag};
    else if (sel_cd)
    begin
      next_rdata[CD_START_BIT]             = cd_busy;
      next_rdata[CD_RESULT_HI:CD_RESULT_LO] = cd_result;
      next_rdata[CD_SHORT_BIT]             = cd_short;
      next_rdata[CD_RSVD_HI:CD_RSVD_LO]    = cd_rsvd;
      next_rdata[CD_DIST_HI:0]             = cd_dist;
    end
    else if (sel_ps)
    begin
      next_rdata[PS_PAUSE_BIT] = stat_q.pause_capable;
      next_rdata[PS_LINK_BIT]  = stat_q.link_up;
      next_rdata[PS_POL_BIT]   = stat_q.polarity_rev;
    end
    else if (sel_pc)
      next_rdata[PC_INT_LEVEL_BIT] = int_level;
  end

  // read data registered at setup; holds the pre-clear flag image
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= {16'h0000, next_rdata};
  end

endmodule

`default_nettype wire

/* verification/pics_regs_properties.sv */
// port checker for the register bank
`timescale 1ns/1ns
`default_nettype none
module pics_regs_properties
  import pics_pkg::*;
(
  input wire logic            clk_sys,
  input wire logic            rst,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [11:0]     paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire pics_events_t    events,
  input wire pics_cd_report_t cd_report,
  input wire pics_status_t    status,
  input wire logic            cd_start,
  input wire logic            irq_pin
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // setup cycle and decoded map
  wire setup = psel & ~penable;
  wire mapped = paddr inside {12'h06c, 12'h074, 12'h078, 12'h07c};
  sequence s_rd_stat;
    setup && !pwrite && paddr == 12'h078;
  endsequence
  a_ready_next: assert property (setup |=> pready) else $error("no pready");
  a_ready_once: assert property (pready |=> !pready) else $error("pready held");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper bits set");
  a_bad_addr: assert property (setup && !mapped |=> pslverr && (prdata == 32'h0 || $past(pwrite))) else $error("no error");
  a_good_addr: assert property (setup && mapped |=> !pslverr) else $error("false error");
  a_start_once: assert property (cd_start |=> !cd_start) else $error("start held");
  a_start_cause: assert property (cd_start |-> $past(psel && pwrite && paddr == 12'h074)) else $error("stray start");
  a_stat_read: assert property (s_rd_stat |=> prdata[9:7] == $past(status, 2)) else $error("bad status");
  a_reset_quiet: assert property ($fell(rst) |-> !pready && !cd_start && irq_pin) else $error("busy at reset");
endmodule
bind pics_regs pics_regs_properties i_props (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .events(events), .cd_report(cd_report), .status(status), .cd_start(cd_start), .irq_pin(irq_pin));
`default_nettype wire

/* verification/pics_cable_model.sv */
// cable test engine model
`timescale 1ns/1ns
`default_nettype none
module pics_cable_model
  import pics_pkg::*;
#(
  parameter int DLY = 5
)
(
  input wire logic            clk_sys,
  input wire logic            rst,
  input wire logic            cd_start,
  input wire pics_cd_report_t res,
  output var pics_cd_report_t cd_report
);
  int cnt;
  // report once per start; junk outside the done cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cnt <= 0;
    else if (cd_start)
      cnt <= DLY;
    else if (cnt > 0)
      cnt <= cnt - 1;
    cd_report <= (cnt == 1) ? res : {1'b0, ~res[11:0]};
  end
endmodule
`default_nettype wire

/* verification/pics_regs_tb.sv */
// self-checking bench for the register bank
`timescale 1ns/1ns
`default_nettype none
module pics_regs_tb
  import pics_pkg::*;
;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, cd_start, irq_pin, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  pics_events_t events;
  pics_cd_report_t cd_report, res;
  pics_status_t status;
  int n_mismatch, cmp_count;
  pics_regs i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .events(events), .cd_report(cd_report), .status(status), .cd_start(cd_start), .irq_pin(irq_pin));
  pics_cable_model i_cable (.clk_sys(clk_sys), .rst(rst), .cd_start(cd_start), .res(res), .cd_report(cd_report));
  // free-running clock
  initial
  begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits for pready under a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      n_mismatch++;
      test_done;
    end
  endtask
  task pulse(input logic [7:0] e);
    @(posedge clk_sys);
    events <= e;
    @(posedge clk_sys);
    events <= 8'h00;
  endtask
  task settle;
    repeat (2) @(posedge clk_sys);
  endtask
  task t_reset;
    apb(0, 12'h06c, 0);
    chk(rd, 0);
    apb(0, 12'h074, 0);
    chk(rd, 0);
    apb(0, 12'h078, 0);
    chk(rd, 0);
    chk(irq_pin, 1);
    $display("reset test done");
  endtask
  task t_flags;
    for (int i = 0; i < 8; i++)
    begin
      pulse(8'(1 << i));
      apb(0, 12'h06c, 0);
      chk(rd, 32'(1 << i));
      apb(0, 12'h06c, 0);
      chk(rd, 0);
    end
    $display("flag test done");
  endtask
  task t_irq;
    apb(1, 12'h06c, 32'hff00);
    pulse(8'h80);
    settle;
    chk(irq_pin, 0);
    apb(0, 12'h06c, 0);
    chk(rd, 32'hff80);
    settle;
    chk(irq_pin, 1);
    apb(1, 12'h07c, 32'h0200);
    settle;
    chk(irq_pin, 0);
    pulse(8'h01);
    settle;
    chk(irq_pin, 1);
    apb(0, 12'h06c, 0);
    apb(1, 12'h06c, 32'h0200);
    pulse(8'h80);
    settle;
    chk(irq_pin, 0);
    pulse(8'h02);
    settle;
    chk(irq_pin, 1);
    apb(0, 12'h06c, 0);
    $display("interrupt test done");
  endtask
  task t_cable;
    int n;
    for (int r = 0; r < 4; r++)
    begin
      res <= {1'b1, 2'(r), 1'(r), 9'(9'h0a5 + r)};
      apb(1, 12'h074, 32'h8000);
      apb(0, 12'h074, 0);
      chk(rd[15], 1);
      n = 0;
      do
      begin
        apb(0, 12'h074, 0);
        n++;
      end
      while (rd[15] !== 1'b0 && n < 50);
      if (n >= 50)
      begin
        n_mismatch++;
        test_done;
      end
      chk(rd, {16'h0, 1'b0, 2'(r), 1'(r), 3'h0, 9'(9'h0a5 + r)});
    end
    $display("cable test done");
  endtask
  task t_status;
    status <= 3'b101;
    settle;
    apb(0, 12'h078, 0);
    chk(rd, 32'h0280);
    status <= 3'b010;
    settle;
    apb(0, 12'h078, 0);
    chk(rd, 32'h0100);
    apb(0, 12'h080, 0);
    chk({er, rd[30:0]}, 32'h80000000);
    $display("status test done");
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    rst = 1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    events = '0;
    status = '0;
    res = '0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    t_reset;
    t_flags;
    t_irq;
    t_cable;
    t_status;
    test_done;
  end
endmodule
`default_nettype wire
